/* hw/one_time_watchdog.sv */
// One-time-enabled watchdog with reset-out, AHB-Lite register slave
//
// Function
// - 14-bit counter, write-only service register, unreadable
// - Watchdog disabled after any reset
// - Writing 1E then E1 enables watchdog
// - Enabled counter increments once per machine cycle
// - No software way to disable it
// - Counter reaching 3FFF is overflow, resets device
// - Overflow drives high pulse on reset pin
// - 1E then E1 while enabled restarts counter
// - Service register reads zero, writes only sequence
// - Idle-halt bit 4 freezes count during idle
// - Reset pin pulse lasts 98 oscillator periods
// - After power-down wake, hold until interrupt high
`timescale 1ns/1ps

module one_time_watchdog
    import watchdog_pkg::*;
#(
    parameter int CNT_W   = CNT_WIDTH,          // Counter width
    parameter int MC_DIV  = OSC_PER_MACHINE,    // Clocks per machine cycle
    parameter int PULSE_N = RESET_PULSE_CYCLES  // Reset-out length, clocks
)(
    input  wire logic        clk,         // Oscillator clock, 50 MHz
    input  wire logic        rst,         // Hardware reset, sync, high
    input  wire logic        hsel,        // AHB-Lite slave select
    input  wire logic [31:0] haddr,       // AHB-Lite address
    input  wire logic [1:0]  htrans,      // AHB-Lite transfer type
    input  wire logic        hwrite,      // AHB-Lite write
    input  wire logic [2:0]  hsize,       // AHB-Lite size, word only
    input  wire logic [31:0] hwdata,      // AHB-Lite write data
    input  wire logic        hready,      // AHB-Lite bus ready
    output logic      [31:0] hrdata,      // AHB-Lite read data
    output logic             hreadyout,   // AHB-Lite slave ready
    output logic             hresp,       // AHB-Lite response, OKAY
    input  wire logic        idle_mode,   // CPU is in idle
    input  wire logic        power_down,  // Oscillator stopped
    input  wire logic        wake_int_n,  // Level wake interrupt, low
    input  wire logic        rst_pin_in,  // Level seen on reset pin
    output logic             rst_pin_out, // Value driven on reset pin
    output logic             rst_pin_oe,  // Reset pin driven when high
    output logic             wdt_reset    // Internal device reset request
);

    localparam int DIV_W   = (MC_DIV > 1) ? $clog2(MC_DIV) : 1;
    localparam int PULSE_W = (PULSE_N > 1) ? $clog2(PULSE_N) : 1;

    // Refuse sizes the logic cannot serve
    if (CNT_W < 2 || CNT_W > 24 || MC_DIV < 1 || PULSE_N < 1)
    begin : g_bad_param
        $error("one_time_watchdog: unsupported parameter value");
    end

    // All state of the block in one register
    typedef struct packed {
        logic [DIV_W-1:0]   mc_div;      // Machine-cycle divider
        logic [CNT_W-1:0]   counter;     // Watchdog count, not readable
        logic               enabled;     // Counter running
        logic               armed;       // First sequence byte seen
        logic [PULSE_W-1:0] pulse_cnt;   // Remaining reset-out clocks
        logic               pulse_active; // Overflow reset in progress
        logic               pin_drive;   // Reset pin driven high
        logic               wd_caused;   // An overflow has happened
        logic               idle_halt;   // Freeze count during idle
        logic               rst_out_dis; // Reset pin input only
        logic               pd_hold;     // Waiting for wake line high
        logic               pd_prev;     // Power-down one clock ago
        logic               wr_pend;     // Write data phase pending
        logic [7:0]         wr_idx;      // Register index of the write
        logic [31:0]        rdata;       // Read data for data phase
        logic               ready;       // Slave ready
    } state_t;

    state_t s;      // Registered state
    state_t next_s; // Next state

    logic mc_tick;  // Last clock of a machine cycle
    logic addr_ok;  // Valid address phase taken this edge
    logic in_map;   // Address within the register window
    logic svc_wr;   // Write data phase to the service register
    logic aux_wr;   // Write data phase to auxiliary control
    logic seq_done; // Second byte completes the sequence
    logic run;      // Counter may advance this clock
    logic overflow; // Enabled counter at its top value

    // Next-state logic
    always_comb
    begin
        next_s   = s;
        mc_tick  = (s.mc_div == DIV_W'(MC_DIV - 1));
        addr_ok  = hsel && htrans[1] && hready;
        in_map   = (haddr[31:10] == 22'h000000);
        svc_wr   = s.wr_pend && (s.wr_idx == SVC_IDX);
        aux_wr   = s.wr_pend && (s.wr_idx == AUX_IDX);
        seq_done = svc_wr && s.armed && (hwdata[7:0] == SEQ_SECOND);
        // Oscillator stopped or wake pending means no machine cycles
        run = s.enabled && mc_tick && !power_down
              && !(!wake_int_n && (s.pd_hold || s.pd_prev))
              && !(idle_mode && s.idle_halt);
        overflow = s.enabled && (s.counter == {CNT_W{1'b1}});

        // Free-running machine-cycle divider
        if (mc_tick)
        begin
            next_s.mc_div = '0;
        end
        else
        begin
            next_s.mc_div = s.mc_div + 1'b1;
        end

        // Bus address phase: capture writes, prepare read data
        next_s.ready   = 1'b1;
        next_s.wr_pend = addr_ok && hwrite && in_map;
        next_s.wr_idx  = haddr[9:2];
        if (addr_ok && !hwrite)
        begin
            next_s.rdata = 32'h00000000;
            if (in_map && haddr[9:2] == AUX_IDX)
            begin
                // Reserved bits read as zero
                next_s.rdata[AUX_IDLE_HALT_BIT]     = s.idle_halt;
                next_s.rdata[AUX_RESET_OUT_DIS_BIT] = s.rst_out_dis;
            end
            else if (in_map && haddr[9:2] == STATUS_IDX)
            begin
                next_s.rdata[ST_ENABLED_BIT]  = s.enabled;
                next_s.rdata[ST_ARMED_BIT]    = s.armed;
                next_s.rdata[ST_PULSE_BIT]    = s.pulse_active;
                next_s.rdata[ST_PIN_BIT]      = rst_pin_in;
                next_s.rdata[ST_WD_CAUSE_BIT] = s.wd_caused;
                next_s.rdata[ST_PD_HOLD_BIT]  = s.pd_hold;
            end
            else
            begin
                // Service register and unmapped words read zero
                next_s.rdata = 32'h00000000;
            end
        end

        // Sequence detector: only a first byte arms it
        if (svc_wr)
        begin
            next_s.armed = (hwdata[7:0] == SEQ_FIRST);
        end

        // Auxiliary control write
        if (aux_wr)
        begin
            next_s.idle_halt   = hwdata[AUX_IDLE_HALT_BIT];
            next_s.rst_out_dis = hwdata[AUX_RESET_OUT_DIS_BIT];
        end

        // Counter: overflow beats service, service beats counting
        if (overflow)
        begin
            next_s.enabled = 1'b0;
            next_s.counter = '0;
            next_s.armed   = 1'b0;
        end
        else if (seq_done)
        begin
            next_s.enabled = 1'b1;
            next_s.counter = '0;
        end
        else if (run)
        begin
            next_s.counter = s.counter + 1'b1;
        end

        // Reset-out pulse timer
        if (overflow)
        begin
            next_s.pulse_active = 1'b1;
            next_s.pulse_cnt    = PULSE_W'(PULSE_N - 1);
            next_s.wd_caused    = 1'b1;
        end
        else if (s.pulse_active)
        begin
            if (s.pulse_cnt == '0)
            begin
                next_s.pulse_active = 1'b0;
            end
            else
            begin
                next_s.pulse_cnt = s.pulse_cnt - 1'b1;
            end
        end
        // Pin driven only while pulsing and not disabled
        next_s.pin_drive = next_s.pulse_active && !next_s.rst_out_dis;

        // Leaving power-down with the wake line low holds the count
        next_s.pd_prev = power_down;
        if (s.pd_prev && !power_down && !wake_int_n)
        begin
            next_s.pd_hold = 1'b1;
        end
        else if (wake_int_n)
        begin
            next_s.pd_hold = 1'b0;
        end

        // Hardware reset: everything cleared, bus ready
        if (rst)
        begin
            next_s             = '0;
            next_s.rst_out_dis = AUX_RESET[AUX_RESET_OUT_DIS_BIT];
            next_s.idle_halt   = AUX_RESET[AUX_IDLE_HALT_BIT];
            next_s.ready       = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk)
    begin
        s <= next_s;
    end

    // Outputs straight from the state register, hresp tied to OKAY
    assign hrdata      = s.rdata;
    assign hreadyout   = s.ready;
    assign hresp       = 1'b0;
    assign rst_pin_out = s.pin_drive;
    assign rst_pin_oe  = s.pin_drive;
    assign wdt_reset   = s.pulse_active;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_first_byte;
        svc_wr && hwdata[7:0] == SEQ_FIRST;
    endsequence

    sequence s_second_byte;
        svc_wr && hwdata[7:0] == SEQ_SECOND;
    endsequence

    property p_enable_seq;
        s_first_byte ##1 (!svc_wr)[*2] ##1 s_second_byte
        |=> s.enabled || s.pulse_active;
    endproperty
    a_enable_seq: assert property (p_enable_seq)
        else $error("sequence did not enable watchdog");

    property p_reset_disabled;
        @(posedge clk) rst |=> !s.enabled && s.counter == '0;
    endproperty
    a_reset_disabled: assert property (p_reset_disabled)
        else $error("watchdog active after reset");

    property p_count_step;
        run && !overflow && !seq_done
        |=> s.counter == $past(s.counter) + 1'b1;
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("counter did not step on machine cycle");

    property p_no_sw_disable;
        s.enabled && !overflow |=> s.enabled;
    endproperty
    a_no_sw_disable: assert property (p_no_sw_disable)
        else $error("watchdog disabled without overflow");

    property p_overflow;
        s.enabled && s.counter == {CNT_W{1'b1}}
        |=> !s.enabled && s.counter == '0 && wdt_reset;
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("overflow did not reset watchdog");

    property p_pin_pulse;
        overflow && !s.rst_out_dis && !aux_wr
        |=> (rst_pin_oe && rst_pin_out)[*8];
    endproperty
    a_pin_pulse: assert property (p_pin_pulse)
        else $error("reset pin not driven after overflow");

    property p_pin_disabled;
        s.rst_out_dis && !$rose(s.rst_out_dis) |-> !rst_pin_oe;
    endproperty
    a_pin_disabled: assert property (p_pin_disabled)
        else $error("reset pin driven while disabled");

    property p_pulse_len;
        $rose(wdt_reset) |-> ##(PULSE_N - 1) wdt_reset ##1 !wdt_reset;
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("reset pulse length wrong");

    sequence s_armed_running;
        s.enabled && s.armed && !overflow;
    endsequence

    property p_service;
        s_second_byte and s_armed_running
        |=> s.counter == '0 && s.enabled;
    endproperty
    a_service: assert property (p_service)
        else $error("service did not restart counter");

    property p_bad_write;
        svc_wr && hwdata[7:0] != SEQ_FIRST && !seq_done && !overflow
        |=> !s.armed && s.enabled == $past(s.enabled)
            && (s.counter == $past(s.counter)
                || s.counter == $past(s.counter) + 1'b1);
    endproperty
    a_bad_write: assert property (p_bad_write)
        else $error("out-of-sequence write had effect");

    property p_svc_read_zero;
        addr_ok && !hwrite && in_map && haddr[9:2] == SVC_IDX
        |=> hrdata == 32'h00000000;
    endproperty
    a_svc_read_zero: assert property (p_svc_read_zero)
        else $error("service register read not zero");

    property p_idle_freeze;
        s.enabled && idle_mode && s.idle_halt && !overflow && !seq_done
        |=> $stable(s.counter);
    endproperty
    a_idle_freeze: assert property (p_idle_freeze)
        else $error("counter moved during halted idle");

    property p_wake_hold;
        s.pd_hold && !wake_int_n && !overflow && !seq_done
        |=> $stable(s.counter);
    endproperty
    a_wake_hold: assert property (p_wake_hold)
        else $error("counter moved before wake line high");

endmodule : one_time_watchdog

/* hw/watchdog_pkg.sv */
// Constants shared by the one-time watchdog with reset-out
package watchdog_pkg;

    // Counter and machine-cycle timing
    localparam int CNT_WIDTH         = 14;  // Watchdog counter width
    localparam int OSC_PER_MACHINE   = 12;  // Oscillator periods per cycle
    localparam int OSC_PERIOD_PS     = 20000; // One clk period is one osc
    localparam int RESET_PULSE_OSC   = 98;  // Reset-out length, osc periods
    localparam int RESET_PULSE_PS    = RESET_PULSE_OSC * OSC_PERIOD_PS;
    // Pulse length in clk cycles, rounded up to whole cycles
    localparam int RESET_PULSE_CYCLES =
        (RESET_PULSE_PS + OSC_PERIOD_PS - 1) / OSC_PERIOD_PS;

    // Register indices; byte address is four times the index
    localparam logic [7:0] AUX_IDX    = 8'h8E; // Auxiliary control
    localparam logic [7:0] SVC_IDX    = 8'hA6; // Watchdog service
    localparam logic [7:0] STATUS_IDX = 8'hC0; // Watchdog status

    // Service sequence bytes
    localparam logic [7:0] SEQ_FIRST  = 8'h1E;
    localparam logic [7:0] SEQ_SECOND = 8'hE1;

    // Auxiliary control field positions and reset value
    localparam int         AUX_RESET_OUT_DIS_BIT = 3;
    localparam int         AUX_IDLE_HALT_BIT     = 4;
    localparam logic [7:0] AUX_RESET             = 8'h00;

    // Status field positions
    localparam int ST_ENABLED_BIT  = 0;
    localparam int ST_ARMED_BIT    = 1;
    localparam int ST_PULSE_BIT    = 2;
    localparam int ST_PIN_BIT      = 3;
    localparam int ST_WD_CAUSE_BIT = 4;
    localparam int ST_PD_HOLD_BIT  = 5;

endpackage : watchdog_pkg

/* sim/one_time_watchdog_reset_out_test.sv */
// Self-checking bench for the one-time watchdog with reset-out
`timescale 1ns/1ps

module one_time_watchdog_reset_out_test
    import watchdog_pkg::*;
;
    localparam int CW = 4;  // Short counter keeps overflow runs brief
    localparam int PN = 8;  // Short reset-out pulse
    localparam int FULL = 2 ** CW;  // Cycles from restart to overflow

    logic        clk = 1'b0;          // 50 MHz clock
    logic        rst = 1'b1;          // Sync reset, high
    logic        hsel = 1'b0;         // Bus select
    logic [31:0] haddr = 32'h0;       // Bus address
    logic [1:0]  htrans = 2'h0;       // Bus transfer type
    logic        hwrite = 1'b0;       // Bus direction
    logic [2:0]  hsize = 3'h2;        // Always one word
    logic [31:0] hwdata = 32'h0;      // Bus write data
    wire logic   hready;              // Single slave, ready loops back
    logic [31:0] hrdata;              // Read data
    logic        hreadyout;           // Slave ready
    logic        hresp;               // Slave response
    logic        idle_mode = 1'b0;    // CPU idle level
    logic        power_down = 1'b0;   // Oscillator stopped
    logic        wake_int_n = 1'b1;   // Wake interrupt, low
    logic        rst_pin_in = 1'b0;   // Level on reset pin
    logic        rst_pin_out;         // Driven pin value
    logic        rst_pin_oe;          // Pin drive enable
    logic        wdt_reset;           // Internal reset request
    int          fail_count = 0;      // Mismatches seen
    int          comparisons = 0;     // Comparisons made
    logic [63:0] rd_q[$];             // Expected read value and mask
    logic [63:0] rd_note;             // Oldest read note taken off
    logic [31:0] pulse_q[$];          // Expected pulse length and pin
    logic        rd_pend = 1'b0;      // Read data phase under way
    int          plen = 0;            // Pulse cycles counted
    int          ppin = 0;            // Pin-driven cycles counted
    int          n;                   // Cycles to overflow
    logic [31:0] v;                   // Random register value

    assign hready = hreadyout;

    // Free-running clock
    always #10 clk = ~clk;

    one_time_watchdog #(.CNT_W(CW), .MC_DIV(1), .PULSE_N(PN)) dut (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .idle_mode(idle_mode),
        .power_down(power_down), .wake_int_n(wake_int_n),
        .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out),
        .rst_pin_oe(rst_pin_oe), .wdt_reset(wdt_reset)
    );

    // Ends the run with the counts and the verdict
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    // Compares a word under a mask
    task automatic check_word(input logic [31:0] e, g, m);
        comparisons++;
        if ((g & m) !== (e & m))
        begin
            fail_count++;
            $display("mismatch at %0t exp %h got %h", $time, e, g);
        end
    endtask : check_word

    // Compares a pulse as {length, pin cycles}
    task automatic check_pulse(input logic [31:0] e, g);
        comparisons++;
        if (g !== e)
        begin
            fail_count++;
            $display("mismatch at %0t pulse exp %h got %h", $time, e, g);
        end
    endtask : check_pulse

    // Waits for hready at a rising edge; a hang ends the run
    task automatic wait_ready();
        int k;
        for (k = 0; k < 50; k++)
        begin
            @(posedge clk);
            if (hreadyout === 1'b1)
                return;
        end
        fail_count++;
        give_verdict();
    endtask : wait_ready

    // One single-word transfer, address phase then data phase
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
    endtask : bus

    // Read with the expectation noted first
    task automatic rd(input logic [7:0] idx, input logic [31:0] e, m);
        rd_q.push_back({e, m});
        bus(1'b0, idx, 32'h0);
    endtask : rd

    // Two-byte enable or restart sequence
    task automatic svc();
        bus(1'b1, SVC_IDX, {24'h0, SEQ_FIRST});
        bus(1'b1, SVC_IDX, {24'h0, SEQ_SECOND});
    endtask : svc

    // Notes a pulse, counts cycles to its start, waits for its end
    task automatic overflow(input int pin);
        int k;
        pulse_q.push_back({16'(PN), 16'(pin)});
        for (n = 1; n <= 300 && wdt_reset !== 1'b1; n++)
        begin
            @(posedge clk);
            #1;
        end
        n--;
        for (k = 0; k < PN + 8 && wdt_reset === 1'b1; k++)
            @(posedge clk);
        if (k >= PN + 8 || n >= 300)
        begin
            fail_count++;
            give_verdict();
        end
        @(posedge clk);
    endtask : overflow

    // Output watcher: read data at the data-phase edge, pulse shapes
    always @(posedge clk)
    begin
        if (rd_pend && hreadyout === 1'b1)
        begin
            if (rd_q.size() == 0)
                fail_count++;
            else
            begin
                rd_note = rd_q.pop_front();
                check_word(rd_note[63:32], hrdata, rd_note[31:0]);
            end
            check_word(32'h0, {31'h0, hresp}, 32'h1);
        end
        rd_pend = hsel && htrans[1] && !hwrite && hreadyout === 1'b1;
        if (wdt_reset === 1'b1)
        begin
            plen++;
            ppin += (rst_pin_oe === 1'b1 && rst_pin_out === 1'b1);
        end
        else if (plen != 0)
        begin
            // Stray pulse meets an empty queue and compares against 0
            check_pulse(pulse_q.size() ? pulse_q.pop_front() : 32'h0,
                        {plen[15:0], ppin[15:0]});
            plen = 0;
            ppin = 0;
        end
    end

    // Main sequence
    initial
    begin
        v = $urandom(11);
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(AUX_IDX, 32'h0, '1);
        rd(SVC_IDX, 32'h0, '1);
        rd(STATUS_IDX, 32'h0, 32'h13);
        rd(8'h10, 32'h0, '1);
        v = $urandom;
        rst_pin_in <= v[3];
        rd(STATUS_IDX, v & 32'h8, 32'h8);
        bus(1'b1, AUX_IDX, v);
        rd(AUX_IDX, v & 32'h18, '1);
        $display("test reset and registers done");
        bus(1'b1, AUX_IDX, 32'h0);
        bus(1'b1, SVC_IDX, {24'h0, SEQ_SECOND});
        rd(STATUS_IDX, 32'h0, 32'h3);
        bus(1'b1, SVC_IDX, {24'h0, SEQ_FIRST});
        bus(1'b1, SVC_IDX, 32'h55);
        bus(1'b1, SVC_IDX, {24'h0, SEQ_SECOND});
        rd(STATUS_IDX, 32'h0, 32'h3);
        svc();
        rd(STATUS_IDX, 32'h1, 32'h3);
        repeat (6)
        begin
            repeat (1 + $urandom % 5) @(posedge clk);
            svc();
        end
        overflow(PN);
        check_word(32'(FULL), 32'(n), '1);
        rd(STATUS_IDX, 32'h10, 32'h13);
        $display("test enable, service, overflow done");
        bus(1'b1, AUX_IDX, 32'h8);
        svc();
        overflow(0);
        $display("test reset-out disabled done");
        bus(1'b1, AUX_IDX, 32'h10);
        idle_mode <= 1'b1;
        svc();
        repeat (40) @(posedge clk);
        idle_mode <= 1'b0;
        overflow(PN);
        check_word(32'(FULL), 32'(n), '1);
        $display("test idle halt done");
        bus(1'b1, AUX_IDX, 32'h0);
        power_down <= 1'b1;
        wake_int_n <= 1'b0;
        svc();
        repeat (30) @(posedge clk);
        power_down <= 1'b0;
        rd(STATUS_IDX, 32'h21, 32'h21);
        repeat (27) @(posedge clk);
        wake_int_n <= 1'b1;
        overflow(PN);
        check_word(32'(FULL), 32'(n), '1);
        $display("test power-down wake hold done");
        svc();
        repeat (5) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (40) @(posedge clk);
        rd(STATUS_IDX, 32'h0, 32'h13);
        $display("test reset while enabled done");
        give_verdict();
    end

endmodule : one_time_watchdog_reset_out_test
